// ==== bidirectional_port_pin.v ====
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Function
// - three bit registers per pin, separate addresses
// - direction bit one makes pin output
// - input with output bit one enables pull-up
// - global disable suppresses all pull-ups
// - output drives output bit value, no pull-up
// - reset tri-states pins without a clock
// - writing one to input bit toggles output
// - pin level read via two-stage synchronizer
// - strobes shared per port, controls shared
// - alternate pins leave other pins usable
// - scan enable forces input, no pull-up
module bidirectional_port_pin (
   // clock and reset
   input wire clk,
   input wire arst_n,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   // pins
   input wire [7:0] pinIn,
   output wire [7:0] pinOut,
   output wire [7:0] pinOe,
   output wire [7:0] pullupEn,
   // digital input enable toward pin-change logic
   output wire [7:0] inputEnableOverrideEnable,
   output wire [7:0] inputEnableOverrideValue
);
`include "gpio_port_consts.vh"

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [7:0] portDirectionReg;
   reg [7:0] portOutputReg;
   reg pullupDisableAll;
   reg [3:0] altCtrl;
   wire [7:0] portInputReg;
   wire [7:0] pullupOverrideEnable;
   wire [7:0] directionOverrideEnable;
   wire jtagEnable;
   wire pinChangeGroup2Enable;
   wire pinChangeMaskPc2;
   wire pinChangeMaskPc3;
   wire access;
   wire wrAccess;

   function hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   function known;
      input [11:0] a;
      begin
         known = hit(a, `OFS_INPUT) | hit(a, `OFS_DIRECTION) | hit(a, `OFS_OUTPUT)
            | hit(a, `OFS_CONTROL) | hit(a, `OFS_ALTERNATE);
      end
   endfunction

   assign access = psel & penable;
   assign wrAccess = access & pwrite;
   assign pready = 1'b1;
   assign pslverr = access & ~known(paddr);

   assign jtagEnable = altCtrl[`ALT_JTAG_BIT];
   assign pinChangeGroup2Enable = altCtrl[`ALT_PIN_CHANGE_GROUP2_ENABLE_BIT];
   assign pinChangeMaskPc2 = altCtrl[`ALT_MASK_PC2_BIT];
   assign pinChangeMaskPc3 = altCtrl[`ALT_MASK_PC3_BIT];

   // ----------------------------------------
   // scan-port overrides, other pins untouched
   // ----------------------------------------
   assign pullupOverrideEnable = {4'h0, jtagEnable, jtagEnable, 2'h0};
   assign directionOverrideEnable = pullupOverrideEnable;
   assign inputEnableOverrideEnable = {4'h0,
      jtagEnable | (pinChangeMaskPc3 & pinChangeGroup2Enable),
      jtagEnable | (pinChangeMaskPc2 & pinChangeGroup2Enable), 2'h0};
   assign inputEnableOverrideValue = {4'h0, jtagEnable, jtagEnable, 2'h0};

   // ----------------------------------------
   // register writes, shared per-port strobes
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         portDirectionReg <= `RST_PORT;
         portOutputReg <= `RST_PORT;
         pullupDisableAll <= `RST_BIT;
         altCtrl <= 4'h0;
      end else if (wrAccess) begin
         if (hit(paddr, `OFS_DIRECTION)) begin
            portDirectionReg <= pwdata[7:0];
         end
         if (hit(paddr, `OFS_OUTPUT)) begin
            portOutputReg <= pwdata[7:0];
         end
         if (hit(paddr, `OFS_INPUT)) begin
            portOutputReg <= portOutputReg ^ pwdata[7:0];
         end
         if (hit(paddr, `OFS_CONTROL)) begin
            pullupDisableAll <= pwdata[`CTL_PUD_BIT];
         end
         if (hit(paddr, `OFS_ALTERNATE)) begin
            altCtrl <= pwdata[3:0];
         end
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always @* begin
      prdata = 32'h0000_0000;
      if (hit(paddr, `OFS_INPUT)) begin
         prdata = {24'h000000, portInputReg};
      end else if (hit(paddr, `OFS_DIRECTION)) begin
         prdata = {24'h000000, portDirectionReg};
      end else if (hit(paddr, `OFS_OUTPUT)) begin
         prdata = {24'h000000, portOutputReg};
      end else if (hit(paddr, `OFS_CONTROL)) begin
         prdata = {31'h00000000, pullupDisableAll};
      end else if (hit(paddr, `OFS_ALTERNATE)) begin
         prdata = {28'h0000000, altCtrl};
      end
   end

   // ----------------------------------------
   // pin path
   // ----------------------------------------
   pin_sync u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .asyncIn(pinIn),
      .syncOut(portInputReg)
   );

   pad_ctrl u_pad (
      .arst_n(arst_n),
      .dirBits(portDirectionReg),
      .outBits(portOutputReg),
      .pullupDisableAll(pullupDisableAll),
      .pullupOverrideEnable(pullupOverrideEnable),
      .pullupOverrideValue(8'h00),
      .directionOverrideEnable(directionOverrideEnable),
      .directionOverrideValue(8'h00),
      .padOut(pinOut),
      .padOe(pinOe),
      .pullupEn(pullupEn)
   );
endmodule // bidirectional_port_pin

// ==== gpio_port_consts.vh ====
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH

// ----------------------------------------
// port geometry
// ----------------------------------------
`define PORT_WIDTH 8
`define ADDR_WIDTH 12

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define OFS_INPUT 12'h000
`define OFS_DIRECTION 12'h004
`define OFS_OUTPUT 12'h008
`define OFS_CONTROL 12'h00C
`define OFS_ALTERNATE 12'h010

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CTL_PUD_BIT 0
`define ALT_JTAG_BIT 0
`define ALT_PIN_CHANGE_GROUP2_ENABLE_BIT 1
`define ALT_MASK_PC2_BIT 2
`define ALT_MASK_PC3_BIT 3
`define ALT_WIDTH 4
`define SCAN_PIN_LO 2
`define SCAN_PIN_HI 3
`define RST_PORT 8'h00
`define RST_BIT 1'b0

`endif

// ==== pin_sync.v ====
`timescale 1ns/1ps
// ----------------------------------------
// two-stage input synchronizer
// ----------------------------------------
module pin_sync (
   // clock and reset
   input wire clk,
   input wire arst_n,
   // data
   input wire [7:0] asyncIn,
   output reg [7:0] syncOut
);
`include "gpio_port_consts.vh"

   reg [7:0] stage1;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1 <= `RST_PORT;
         syncOut <= `RST_PORT;
      end else begin
         stage1 <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule // pin_sync

// ==== pad_ctrl.v ====
`timescale 1ns/1ps
// ----------------------------------------
// per-pin drive, pull-up and override logic
// ----------------------------------------
module pad_ctrl (
   // configuration
   input wire arst_n,
   input wire [7:0] dirBits,
   input wire [7:0] outBits,
   input wire pullupDisableAll,
   // alternate function overrides
   input wire [7:0] pullupOverrideEnable,
   input wire [7:0] pullupOverrideValue,
   input wire [7:0] directionOverrideEnable,
   input wire [7:0] directionOverrideValue,
   // pad controls
   output wire [7:0] padOut,
   output wire [7:0] padOe,
   output wire [7:0] pullupEn
);
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_pin
         wire effDir;
         wire rawPull;
         assign effDir = directionOverrideEnable[i] ? directionOverrideValue[i]
                                                    : dirBits[i];
         assign rawPull = ~dirBits[i] & outBits[i] & ~pullupDisableAll;
         // reset gates pins combinationally, no clock needed
         assign padOe[i] = arst_n & effDir;
         assign padOut[i] = outBits[i];
         assign pullupEn[i] = arst_n & ~effDir & (pullupOverrideEnable[i]
            ? pullupOverrideValue[i] : rawPull);
      end
   endgenerate
endmodule // pad_ctrl

// ==== port_pin_asserts.sv ====
`timescale 1ns/1ps
// ---
// port checks
// ---
module port_pin_asserts (
   // clock, reset, bus
   input logic clk,
   input logic arst_n,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   // pins
   input logic [7:0] pinIn,
   input logic [7:0] pinOut,
   input logic [7:0] pinOe,
   input logic [7:0] pullupEn,
   input logic [7:0] inputEnableOverrideValue
);
   wire wr = psel && penable && pwrite;
   wire [7:0] wd = pwdata[7:0];
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_dir_write:
      assert property (wr && paddr == 12'h004 |=> ((pinOe ^ $past(wd)) & 8'hF3) == 0)
      else $error("drive enable wrong");
   a_out_write:
      assert property (wr && paddr == 12'h008 |=> pinOut == $past(wd)) else $error("out wrong");
   a_toggle_out:
      assert property (wr && paddr == 12'h000 |=> pinOut == ($past(pinOut) ^ $past(wd)))
      else $error("toggle wrong");
   a_pull_off:
      assert property (wr && paddr == 12'h00C && wd[0] |=> pullupEn == 0) else $error("pull on");
   a_reset_tri:
      assert property (disable iff (1'b0) !arst_n |-> pinOe == 0 && pullupEn == 0)
      else $error("not tri-state");
   a_reset_clear:
      assert property ($rose(arst_n) |-> pinOe == 0 && pinOut == 0) else $error("not cleared");
   a_sync_delay:
      assert property (psel && !pwrite && paddr == 0 |-> prdata[7:0] == $past(pinIn, 2))
      else $error("sync delay wrong");
   a_scan_input:
      assert property (inputEnableOverrideValue[2] |-> !pinOe[2] && !pullupEn[2])
      else $error("scan pin driven");
endmodule // port_pin_asserts
bind bidirectional_port_pin port_pin_asserts chk_u (.clk, .arst_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pinIn, .pinOut, .pinOe, .pullupEn, .inputEnableOverrideValue);

// ==== pin_partner.sv ====
`timescale 1ns/1ps
// ---
// outside pad circuitry
// ---
module pin_partner (
   // from the port
   input logic clk,
   input logic [7:0] pinOut,
   input logic [7:0] pinOe,
   input logic [7:0] pullupEn,
   // weak outside keeper
   input logic [7:0] extVal,
   input logic [7:0] extEn,
   output logic [7:0] pinLevel
);
   logic [7:0] flt = 8'h55;
   always @(posedge clk) flt <= ~flt;
   assign pinLevel = pinOe & pinOut | ~pinOe & (pullupEn | extEn & extVal | ~extEn & flt);
endmodule // pin_partner

// ==== test_bidirectional_port_pin.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_bidirectional_port_pin;
   // ---
   // stimulus and checking
   // ---
   logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pullup_disable_all;
   logic pready, pslverr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, ex;
   logic [7:0] pinIn, pinOut, pinOe, pullupEn, ieEn, ieVal, d, o, t;
   logic [7:0] extVal = 0, extEn = 8'hFF;
   logic [31:0] q[$];
   int err_total = 0, checks_done = 0, seed = 92580;
   always #5 clk = ~clk;
   bidirectional_port_pin dut_u (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .pslverr, .prdata, .pinIn, .pinOut, .pinOe, .pullupEn,
      .inputEnableOverrideEnable(ieEn), .inputEnableOverrideValue(ieVal));
   pin_partner ext_u (.clk, .pinOut, .pinOe, .pullupEn, .extVal, .extEn, .pinLevel(pinIn));
   function automatic [7:0] lvl(input [7:0] dr, ou, input pu, input [3:0] am);
      logic [7:0] f, e, p;
      f = {4'h0, am[0], am[0], 2'b00};
      e = dr & ~f;
      p = ou & ~e & ~f & {8{!pu}};
      return (e & ou) | p | (~e & ~p & extVal);
   endfunction
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [7:0] e);
      if (!w) q.push_back({24'h0, e});
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask
   always @(posedge clk) if (psel && penable && pready && !pwrite) begin
      ex = q.pop_front();
      `CHK("prdata", ex, prdata)
      `CHK("pslverr", (paddr == 12'h014), pslverr)
   end
   task results;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      results;
   end
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1;
      apb(0, 12'h004, 0, 0);
      apb(0, 12'h008, 0, 0);
      for (int i = 0; i < 16; i++) begin
         {pullup_disable_all, d, o, t} = 25'($random(seed));
         extVal <= 8'($random(seed));
         apb(1, 12'h004, 0, 0);
         apb(1, 12'h008, o, 0);
         apb(1, 12'h004, d, 0);
         apb(1, 12'h00C, pullup_disable_all, 0);
         apb(1, 12'h010, i, 0);
         @(negedge clk);
         `CHK("pinOe", (d & ~{4'h0, i[0], i[0], 2'h0}), pinOe)
         `CHK("pullupEn", (o & ~d & ~{4'h0, i[0], i[0], 2'h0} & {8{!pullup_disable_all}}), pullupEn)
         `CHK("ieEn", ({4'h0, i[0] | i[3] & i[1], i[0] | i[2] & i[1], 2'h0}), ieEn)
         `CHK("ieVal", ({4'h0, i[0], i[0], 2'h0}), ieVal)
         `CHK("pinOut", o, pinOut)
         apb(0, 12'h000, 0, lvl(d, o, pullup_disable_all, i[3:0]));
         apb(0, 12'h004, 0, d);
         apb(1, 12'h000, t, 0);
         apb(0, 12'h008, 0, o ^ t);
      end
      apb(0, 12'h014, 0, 0);
      @(posedge clk);
      arst_n <= 0;
      @(negedge clk);
      `CHK("pinOe rst", 8'h00, pinOe)
      `CHK("pullupEn rst", 8'h00, pullupEn)
      @(posedge clk);
      arst_n <= 1;
      apb(0, 12'h008, 0, 0);
      apb(0, 12'h004, 0, 0);
      results;
   end
endmodule // test_bidirectional_port_pin
